/* File: common/can_ctl0_pkg.sv */
package can_ctl0_pkg;
   // bus geometry
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int TS_W   = 16;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL0    = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_STAT     = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_IRQ_EN   = 5'h0C;
   localparam logic [ADDR_W-1:0] OFF_IRQ_CLR  = 5'h10;
   localparam logic [ADDR_W-1:0] OFF_TIMER    = 5'h14;
   localparam logic [ADDR_W-1:0] OFF_STAMP    = 5'h18;
   // control register zero bit positions
   localparam int B_RX_FRAME_FLAG  = 7;
   localparam int B_RX_ACTIVE_STATUS  = 6;
   localparam int B_STOPW  = 5;
   localparam int B_SYNC   = 4;
   localparam int B_TIMEN  = 3;
   localparam int B_WAKEN  = 2;
   localparam int B_SLEEP_REQUEST  = 1;
   localparam int B_INIT_REQUEST = 0;
   localparam logic [7:0] CTRL0_RESET = 8'h00;
   // mode status bit positions
   localparam int B_INIT_ACK = 0;
   localparam int B_SLPAK  = 1;
   // event bits
   localparam int EV_N     = 3;
   localparam int EV_RXF   = 0;
   localparam int EV_WAKE  = 1;
   localparam int EV_STAMP = 2;
   // message buffer byte that receives the stamp high byte, low byte follows
   localparam logic [15:0] STAMP_BYTE_ADDR = 16'h000E;
   // controller modes
   typedef enum logic [1:0] {MODE_RUN, MODE_INIT, MODE_SLEEP} mode_e;
endpackage : can_ctl0_pkg

/* File: rtl/can_stamp_timer.sv */
module can_stamp_timer #(
   parameter int TS_W = 16
) (
   // clock and reset
   input  wire logic            clk_in,
   input  wire logic            rst_n_in,
   input  wire logic            clk_en_in,
   // control
   input  wire logic            run_in,
   input  wire logic            tick_in,
   input  wire logic            acked_in,
   // results
   output logic [TS_W-1:0]      count_out,
   output logic [TS_W-1:0]      stamp_out,
   output logic                 stamp_wr_out
);
   logic [TS_W-1:0] count_reg;
   logic [TS_W-1:0] stamp_reg;
   logic            wr_reg;

   // free-running counter, cleared while stopped
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_reg <= '0;
      end else if (clk_en_in) begin
         if (!run_in) begin
            count_reg <= '0;
         end else if (tick_in) begin
            count_reg <= count_reg + 1'b1;
         end
      end
   end

   // capture on acknowledge and pulse the buffer write
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stamp_reg <= '0;
         wr_reg    <= 1'b0;
      end else if (clk_en_in) begin
         wr_reg <= run_in & acked_in;
         if (run_in && acked_in) begin
            stamp_reg <= count_reg;
         end
      end
   end

   assign count_out    = count_reg;
   assign stamp_out    = stamp_reg;
   assign stamp_wr_out = wr_reg;
endmodule : can_stamp_timer

/* File: rtl/can_event_irq.sv */
module can_event_irq #(
   parameter int N = 3
) (
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic         clk_en_in,
   // events and software access
   input  wire logic [N-1:0] set_in,
   input  wire logic         clr_wr_in,
   input  wire logic         en_wr_in,
   input  wire logic [N-1:0] wdata_in,
   // state
   output logic [N-1:0]      status_out,
   output logic [N-1:0]      enable_out,
   output logic              irq_out
);
   logic [N-1:0] status_reg;
   logic [N-1:0] enable_reg;

   // sticky status, a new event beats a clear in the same cycle
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         status_reg <= '0;
      end else if (clk_en_in) begin
         status_reg <= set_in | (status_reg & ~(clr_wr_in ? wdata_in : '0));
      end
   end

   // interrupt enables
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         enable_reg <= '0;
      end else if (clk_en_in && en_wr_in) begin
         enable_reg <= wdata_in;
      end
   end

   assign status_out = status_reg;
   assign enable_out = enable_reg;
   assign irq_out    = |(status_reg & enable_reg);
endmodule : can_event_irq

/* File: rtl/can_control_zero.sv */
// Added by the designer: the register offsets and the Avalon-MM register port.
module can_control_zero
   import can_ctl0_pkg::*;
(
   // clock and reset
   input  wire logic                                clk_in,
   input  wire logic                                rst_n_in,
   input  wire logic                                clk_en_in,
   // avalon-mm slave
   input  wire logic [can_ctl0_pkg::ADDR_W-1:0]     address_in,
   input  wire logic                                read_in,
   input  wire logic                                write_in,
   input  wire logic [can_ctl0_pkg::DATA_W-1:0]     writedata_in,
   input  wire logic [3:0]                          byteenable_in,
   output logic [can_ctl0_pkg::DATA_W-1:0]          readdata_out,
   output logic                                     waitrequest_out,
   // protocol engine status
   input  wire logic                                rx_frame_valid_in,
   input  wire logic                                rx_active_in,
   input  wire logic                                bus_synced_in,
   input  wire logic                                bus_idle_in,
   input  wire logic                                bit_tick_in,
   input  wire logic                                msg_acked_in,
   input  wire logic                                bus_activity_in,
   input  wire logic                                tx_core_in,
   // system mode
   input  wire logic                                wait_mode_in,
   // pin and engine control
   output logic                                     tx_pin_out,
   output logic                                     abort_out,
   output logic                                     clk_gate_out,
   output logic                                     wake_out,
   // timestamp to message buffer
   output logic                                     stamp_wr_out,
   output logic [15:0]                              stamp_addr_out,
   output logic [can_ctl0_pkg::TS_W-1:0]            stamp_data_out,
   // interrupt
   output logic                                     irq_out
);
   import can_ctl0_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // declarations

   logic                ack_reg;
   logic [DATA_W-1:0]   readdata_reg;
   logic                rx_frame_reg;
   logic                stop_in_wait_reg;
   logic                timer_enable_reg;
   logic                wake_enable_reg;
   logic                sleep_request_reg;
   logic                init_request_reg;
   logic                wake_reg;
   mode_e               mode_reg;
   mode_e               mode_next;
   logic                init_ack;
   logic                init_mode;
   logic                out_of_init;
   logic                gated;
   logic                bus_req;
   logic                wr_fire;
   logic                ctrl_wr;
   logic                irq_en_wr;
   logic                irq_clr_wr;
   logic                wake_hit;
   logic                timer_run;
   logic [7:0]          wbyte;
   logic [7:0]          ctrl_view;
   logic [DATA_W-1:0]   rd_mux;
   logic [EV_N-1:0]     ev_set;
   logic [EV_N-1:0]     ev_status;
   logic [EV_N-1:0]     ev_enable;
   logic [TS_W-1:0]     ts_count;

   // address match for one register
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      return a == off;
   endfunction : hit

   ////////////////////////////////////////////////////////////////////////////////////////////
   // mode decode

   // init mode needs both request and acknowledge
   assign init_ack    = (mode_reg == MODE_INIT);
   assign init_mode   = init_request_reg & init_ack;
   assign out_of_init = ~init_request_reg & ~init_ack;
   assign timer_run   = timer_enable_reg & ~init_mode;
   assign wake_hit    = (mode_reg == MODE_SLEEP) & wake_enable_reg & bus_activity_in;

   // clock gate toward the cpu interface during wait
   assign gated        = wait_mode_in & stop_in_wait_reg;
   assign clk_gate_out = gated;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // avalon-mm slave: request seen, one wait cycle, then taken

   assign bus_req         = (read_in | write_in) & ~gated;
   assign waitrequest_out = ~ack_reg;
   assign wr_fire         = write_in & ack_reg & clk_en_in;
   assign wbyte           = writedata_in[7:0];
   assign ctrl_wr         = wr_fire & byteenable_in[0] & hit(address_in, OFF_CTRL0);
   assign irq_en_wr       = wr_fire & byteenable_in[0] & hit(address_in, OFF_IRQ_EN);
   assign irq_clr_wr      = wr_fire & byteenable_in[0] & hit(address_in, OFF_IRQ_CLR);

   // acknowledge strobe, high for exactly one cycle per request
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_reg <= 1'b0;
      end else if (clk_en_in) begin
         ack_reg <= bus_req & ~ack_reg;
      end
   end

   // live view of control register zero
   always_comb begin
      ctrl_view           = CTRL0_RESET;
      ctrl_view[B_RX_FRAME_FLAG]  = rx_frame_reg;
      ctrl_view[B_RX_ACTIVE_STATUS]  = rx_active_in & ~init_mode;
      ctrl_view[B_STOPW]  = stop_in_wait_reg;
      ctrl_view[B_SYNC]   = bus_synced_in & ~init_mode;
      ctrl_view[B_TIMEN]  = timer_enable_reg;
      ctrl_view[B_WAKEN]  = wake_enable_reg;
      ctrl_view[B_SLEEP_REQUEST]  = sleep_request_reg;
      ctrl_view[B_INIT_REQUEST] = init_request_reg;
   end

   // read multiplexer, unmapped offsets read zero
   always_comb begin
      rd_mux = '0;
      case (address_in)
         OFF_CTRL0: begin
            rd_mux = DATA_W'(ctrl_view);
         end
         OFF_STAT: begin
            rd_mux[B_INIT_ACK] = init_ack;
            rd_mux[B_SLPAK]  = (mode_reg == MODE_SLEEP);
         end
         OFF_IRQ_STAT: begin
            rd_mux = DATA_W'(ev_status);
         end
         OFF_IRQ_EN: begin
            rd_mux = DATA_W'(ev_enable);
         end
         OFF_TIMER: begin
            rd_mux = DATA_W'(ts_count);
         end
         OFF_STAMP: begin
            rd_mux = DATA_W'(stamp_data_out);
         end
         default: begin
            rd_mux = '0;
         end
      endcase
   end

   // read data captured when the request is first seen
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         readdata_reg <= '0;
      end else if (clk_en_in && bus_req && !ack_reg && read_in) begin
         readdata_reg <= rd_mux;
      end
   end

   assign readdata_out = readdata_reg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // control register zero

   // received-frame flag, hardware set wins over a clearing write
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_frame_reg <= CTRL0_RESET[B_RX_FRAME_FLAG];
      end else if (clk_en_in) begin
         if (init_mode) begin
            rx_frame_reg <= CTRL0_RESET[B_RX_FRAME_FLAG];
         end else if (rx_frame_valid_in) begin
            rx_frame_reg <= 1'b1;
         end else if (ctrl_wr && out_of_init && wbyte[B_RX_FRAME_FLAG]) begin
            rx_frame_reg <= 1'b0;
         end
      end
   end

   // stop-in-wait and timer enable, held at reset during init
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stop_in_wait_reg <= CTRL0_RESET[B_STOPW];
         timer_enable_reg <= CTRL0_RESET[B_TIMEN];
      end else if (clk_en_in) begin
         if (init_mode) begin
            stop_in_wait_reg <= CTRL0_RESET[B_STOPW];
            timer_enable_reg <= CTRL0_RESET[B_TIMEN];
         end else if (ctrl_wr && out_of_init) begin
            stop_in_wait_reg <= wbyte[B_STOPW];
            timer_enable_reg <= wbyte[B_TIMEN];
         end
      end
   end

   // wake enable keeps its value through init mode
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wake_enable_reg <= CTRL0_RESET[B_WAKEN];
      end else if (clk_en_in && ctrl_wr && out_of_init) begin
         wake_enable_reg <= wbyte[B_WAKEN];
      end
   end

   // init request is writable at any time, cleared only once acknowledged
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         init_request_reg <= CTRL0_RESET[B_INIT_REQUEST];
      end else if (clk_en_in && ctrl_wr) begin
         if (wbyte[B_INIT_REQUEST]) begin
            init_request_reg <= 1'b1;
         end else if (init_ack) begin
            init_request_reg <= 1'b0;
         end
      end
   end

   // sleep request, cleared by bus wake-up or by software once asleep
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sleep_request_reg <= CTRL0_RESET[B_SLEEP_REQUEST];
      end else if (clk_en_in) begin
         if (wake_hit) begin
            sleep_request_reg <= 1'b0;
         end else if (ctrl_wr && out_of_init) begin
            if (wbyte[B_SLEEP_REQUEST]) begin
               sleep_request_reg <= 1'b1;
            end else if (mode_reg == MODE_SLEEP) begin
               sleep_request_reg <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // mode sequencer

   // init wins over sleep; sleep entered only with the bus idle
   always_comb begin
      mode_next = mode_reg;
      unique case (mode_reg)
         MODE_RUN: begin
            if (init_request_reg) begin
               mode_next = MODE_INIT;
            end else if (sleep_request_reg && bus_idle_in) begin
               mode_next = MODE_SLEEP;
            end
         end
         MODE_INIT: begin
            if (!init_request_reg) begin
               mode_next = MODE_RUN;
            end
         end
         MODE_SLEEP: begin
            if (init_request_reg) begin
               mode_next = MODE_INIT;
            end else if (!sleep_request_reg || wake_hit) begin
               mode_next = MODE_RUN;
            end
         end
      endcase
   end

   // mode state
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_reg <= MODE_RUN;
      end else if (clk_en_in) begin
         mode_reg <= mode_next;
      end
   end

   // wake pulse toward the power controller
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wake_reg <= 1'b0;
      end else if (clk_en_in) begin
         wake_reg <= wake_hit;
      end
   end

   assign wake_out  = wake_reg;
   assign abort_out = init_request_reg;

   // transmit pin forced recessive without waiting for a clock edge
   assign tx_pin_out = (gated | init_request_reg) ? 1'b1 : tx_core_in;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // timestamp timer and interrupts

   can_stamp_timer #(
      .TS_W (TS_W)
   ) u_timer (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .clk_en_in    (clk_en_in),
      .run_in       (timer_run),
      .tick_in      (bit_tick_in),
      .acked_in     (msg_acked_in),
      .count_out    (ts_count),
      .stamp_out    (stamp_data_out),
      .stamp_wr_out (stamp_wr_out)
   );

   assign stamp_addr_out = STAMP_BYTE_ADDR;

   // event sources
   always_comb begin
      ev_set           = '0;
      ev_set[EV_RXF]   = rx_frame_valid_in & ~init_mode;
      ev_set[EV_WAKE]  = wake_hit;
      ev_set[EV_STAMP] = stamp_wr_out;
   end

   can_event_irq #(
      .N (EV_N)
   ) u_irq (
      .clk_in     (clk_in),
      .rst_n_in   (rst_n_in),
      .clk_en_in  (clk_en_in),
      .set_in     (ev_set),
      .clr_wr_in  (irq_clr_wr),
      .en_wr_in   (irq_en_wr),
      .wdata_in   (wbyte[EV_N-1:0]),
      .status_out (ev_status),
      .enable_out (ev_enable),
      .irq_out    (irq_out)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   AST_INIT_HOLD: assert property (
      clk_en_in && init_mode |=> !rx_frame_reg && !stop_in_wait_reg && !timer_enable_reg)
      else $error("control bits not held at reset in init mode");

   AST_WRITE_BACK: assert property (
      ctrl_wr && out_of_init && !wait_mode_in |=> wake_enable_reg == $past(wbyte[B_WAKEN]))
      else $error("write outside init mode not taken");

   AST_NO_WRITE_INIT: assert property (
      ctrl_wr && !out_of_init |=> $stable(wake_enable_reg))
      else $error("write accepted during init mode");

   AST_RXF_SET: assert property (
      clk_en_in && rx_frame_valid_in && !init_mode |=> rx_frame_reg)
      else $error("received-frame flag not set");

   AST_RXF_ZERO_WRITE: assert property (
      rx_frame_reg && clk_en_in && !init_mode && !(ctrl_wr && wbyte[B_RX_FRAME_FLAG])
      |=> rx_frame_reg)
      else $error("received-frame flag lost without a one written");

   AST_STATUS_READ: assert property (
      clk_en_in && bus_req && read_in && !ack_reg && hit(address_in, OFF_CTRL0)
      |=> readdata_out[B_SYNC] == $past(bus_synced_in && !init_mode)
          && readdata_out[B_RX_ACTIVE_STATUS] == $past(rx_active_in && !init_mode) && !waitrequest_out)
      else $error("status bits misread");

   AST_TIMER_CLEAR: assert property (
      clk_en_in && !timer_run |=> ts_count == '0)
      else $error("timer not cleared when disabled");

   AST_TIMER_STEP: assert property (
      clk_en_in && timer_run && bit_tick_in |=> ts_count == $past(ts_count) + 1'b1)
      else $error("timer did not advance on bit tick");

   AST_STAMP: assert property (
      clk_en_in && timer_run && msg_acked_in |=> stamp_wr_out && stamp_data_out == $past(ts_count))
      else $error("stamp not written on acknowledge");

   AST_INIT_ACK: assert property (
      clk_en_in && init_request_reg |=> init_ack)
      else $error("init acknowledge missing");

   AST_TX_RECESSIVE: assert property (
      wait_mode_in && stop_in_wait_reg |-> tx_pin_out && clk_gate_out)
      else $error("transmit pin not recessive in wait");

   COV_RX_FRAME: cover property (rx_frame_reg ##1 ctrl_wr ##1 !rx_frame_reg);
   COV_INIT: cover property (init_request_reg ##1 init_mode [*2] ##1 out_of_init);
   COV_WAKE: cover property ((mode_reg == MODE_SLEEP) ##1 wake_out);
   COV_STAMP: cover property (timer_run ##1 stamp_wr_out);
endmodule : can_control_zero

/* File: test/can_engine_model.sv */
module can_engine_model #(
   parameter int TICK_DIV = 4
) (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // bench control
   input  wire logic frame_req_in,
   input  wire logic hold_in,
   // engine status
   output logic      rx_frame_valid_out,
   output logic      rx_active_out,
   output logic      bit_tick_out,
   output logic      msg_acked_out,
   output logic      bus_activity_out,
   output logic      bus_idle_out,
   output logic      tx_core_out
);
   logic [3:0] frm_reg;
   logic [3:0] div_reg;
   // frame in flight: receive window, then valid and acknowledge together
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) frm_reg <= 4'h0;
      else if (frame_req_in) frm_reg <= 4'h6;
      else if (frm_reg != 4'h0) frm_reg <= frm_reg - 4'h1;
   end
   // bit time divider; transmit level changes every bit
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_reg <= 4'h0;
         tx_core_out <= 1'b1;
      end else begin
         div_reg <= (div_reg == 4'(TICK_DIV - 1)) ? 4'h0 : div_reg + 4'h1;
         if (div_reg == 4'h0) tx_core_out <= ~tx_core_out;
      end
   end
   // status levels and strobes
   assign rx_active_out      = hold_in | (frm_reg > 4'h1);
   assign rx_frame_valid_out = (frm_reg == 4'h1);
   assign msg_acked_out      = (frm_reg == 4'h1);
   assign bus_activity_out   = rx_active_out;
   assign bus_idle_out       = ~rx_active_out;
   assign bit_tick_out       = (div_reg == 4'h0);
endmodule : can_engine_model

/* File: test/can_control_zero_tb_top.sv */
module can_control_zero_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import can_ctl0_pkg::*;
   logic              clk_in = 1'b0, rst_n_in = 1'b0, read_in = 1'b0, write_in = 1'b0;
   logic [ADDR_W-1:0] address_in = '0;
   logic [DATA_W-1:0] writedata_in = '0, readdata_out;
   logic              sync = 1'b0, wait_mode = 1'b0, frame_req = 1'b0, hold = 1'b0;
   logic              waitrequest_out, rx_frame_valid_in, rx_active_in, bit_tick_in;
   logic              msg_acked_in, bus_activity_in, bus_idle_in, tx_core_in;
   logic              tx_pin_out, abort_out, clk_gate_out, wake_out, stamp_wr_out, irq_out;
   logic [15:0]       stamp_addr_out;
   logic [TS_W-1:0]   stamp_data_out;
   logic [31:0]       rnd = 32'hC884, q1, q2, q3;
   logic              clk_en = 1'b1;
   int                miscompares = 0, checked = 0;
   always #2 clk_in = ~clk_in;
   can_control_zero u_dut (.clk_in, .rst_n_in, .clk_en_in(clk_en), .address_in, .read_in,
      .write_in, .writedata_in, .byteenable_in(4'hF), .readdata_out, .waitrequest_out,
      .rx_frame_valid_in, .rx_active_in, .bus_synced_in(sync), .bus_idle_in, .bit_tick_in,
      .msg_acked_in, .bus_activity_in, .tx_core_in, .wait_mode_in(wait_mode), .tx_pin_out,
      .abort_out, .clk_gate_out, .wake_out, .stamp_wr_out, .stamp_addr_out,
      .stamp_data_out, .irq_out);
   can_engine_model u_eng (.clk_in, .rst_n_in, .frame_req_in(frame_req), .hold_in(hold),
      .rx_frame_valid_out(rx_frame_valid_in), .rx_active_out(rx_active_in),
      .bit_tick_out(bit_tick_in), .msg_acked_out(msg_acked_in),
      .bus_activity_out(bus_activity_in), .bus_idle_out(bus_idle_in),
      .tx_core_out(tx_core_in));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // besides the two request bits, only stop, timer and wake enables take software data; synced comes from the bench sync signal, not the engine model
   function automatic logic [31:0] ctl_exp(input logic [7:0] d, input logic s);
      return {24'h0, d & 8'h2C} | {27'h0, s, 4'h0};
   endfunction : ctl_exp
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   // one avalon transfer, held until waitrequest is sampled low
   task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_in);
      read_in <= ~w;
      write_in <= w;
      address_in <= a;
      writedata_in <= d;
      do begin
         @(posedge clk_in);
         n++;
      end while (waitrequest_out !== 1'b0 && n < 40);
      q = readdata_out;
      read_in <= 1'b0;
      write_in <= 1'b0;
      if (n >= 40) miscompares++;
   endtask : acc
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic [31:0] q;
      acc(1'b1, a, {24'h0, d}, q);
   endtask : wr
   task automatic rdm(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      acc(1'b0, a, '0, q);
      chk(q & m, e);
   endtask : rdm
   task automatic frame();
      frame_req <= 1'b1;
      @(posedge clk_in);
      frame_req <= 1'b0;
      repeat (8) @(posedge clk_in);
   endtask : frame
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////////////
   // watchdog
   initial begin
      repeat (6000) @(posedge clk_in);
      miscompares++;
      conclude();
   end
   // main sequence
   initial begin
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rdm(OFF_CTRL0, 32'hFFFFFFFF, {24'h0, CTRL0_RESET});
      wr(5'h1C, 8'hFF);
      rdm(5'h1C, 32'hFFFFFFFF, 32'h0);
      for (int i = 0; i < 6; i++) begin
         rnd = xs(rnd);
         sync <= rnd[8];
         wr(OFF_CTRL0, rnd[7:0] & 8'hFC);
         rdm(OFF_CTRL0, 32'hFF, ctl_exp(rnd[7:0], rnd[8]));
      end
      $display("test access done");
      wr(OFF_CTRL0, 8'h00);
      hold <= 1'b1;
      rdm(OFF_CTRL0, 32'h40, 32'h40);
      hold <= 1'b0;
      frame();
      rdm(OFF_CTRL0, 32'h80, 32'h80);
      wr(OFF_CTRL0, 8'h00);
      rdm(OFF_CTRL0, 32'h80, 32'h80);
      wr(OFF_IRQ_EN, 8'h01);
      @(posedge clk_in);
      chk({31'h0, irq_out}, 32'h1);
      wr(OFF_IRQ_EN, 8'h00);
      @(posedge clk_in);
      chk({31'h0, irq_out}, 32'h0);
      wr(OFF_CTRL0, 8'h80);
      rdm(OFF_CTRL0, 32'h80, 32'h0);
      wr(OFF_IRQ_CLR, 8'h07);
      rdm(OFF_IRQ_STAT, 32'h7, 32'h0);
      $display("test flag done");
      wr(OFF_CTRL0, 8'h08);
      repeat (20) @(posedge clk_in);
      acc(1'b0, OFF_TIMER, '0, q1);
      repeat (20) @(posedge clk_in);
      acc(1'b0, OFF_TIMER, '0, q2);
      chk({31'h0, q2 > q1}, 32'h1);
      // clock enable low freezes the counter although bit ticks keep coming
      clk_en <= 1'b0;
      repeat (40) @(posedge clk_in);
      clk_en <= 1'b1;
      acc(1'b0, OFF_TIMER, '0, q3);
      chk({31'h0, (q3 - q2) < 32'h3}, 32'h1);
      frame_req <= 1'b1;
      @(posedge clk_in);
      frame_req <= 1'b0;
      for (int n = 0; n < 20 && stamp_wr_out !== 1'b1; n++) @(posedge clk_in);
      chk({15'h0, stamp_wr_out, stamp_addr_out}, 32'h1000E);
      chk({31'h0, (stamp_data_out - q3[15:0]) < 16'h5}, 32'h1);
      rdm(OFF_IRQ_STAT, 32'h4, 32'h4);
      wr(OFF_CTRL0, 8'h00);
      rdm(OFF_TIMER, 32'hFFFF, 32'h0);
      $display("test timer done");
      wr(OFF_CTRL0, 8'h2C);
      wr(OFF_CTRL0, 8'h2D);
      rdm(OFF_STAT, 32'h1, 32'h1);
      chk({30'h0, abort_out, tx_pin_out}, 32'h3);
      rdm(OFF_CTRL0, 32'hFF, 32'h05);
      wr(OFF_CTRL0, 8'hFF);
      rdm(OFF_CTRL0, 32'hFF, 32'h05);
      wr(OFF_CTRL0, 8'h00);
      rdm(OFF_STAT, 32'h1, 32'h0);
      rdm(OFF_TIMER, 32'hFFFF, 32'h0);
      wr(OFF_CTRL0, 8'h28);
      rdm(OFF_CTRL0, 32'hEF, 32'h28);
      $display("test init done");
      wait_mode <= 1'b1;
      @(posedge clk_in);
      chk({30'h0, clk_gate_out, tx_pin_out}, 32'h3);
      wait_mode <= 1'b0;
      wr(OFF_CTRL0, 8'h00);
      wait_mode <= 1'b1;
      @(posedge clk_in);
      chk({30'h0, clk_gate_out, tx_pin_out ^ tx_core_in}, 32'h0);
      wait_mode <= 1'b0;
      $display("test wait done");
      wr(OFF_IRQ_CLR, 8'h07);
      wr(OFF_CTRL0, 8'h04);
      wr(OFF_CTRL0, 8'h06);
      repeat (4) @(posedge clk_in);
      rdm(OFF_STAT, 32'h2, 32'h2);
      hold <= 1'b1;
      for (int n = 0; n < 8 && wake_out !== 1'b1; n++) @(posedge clk_in);
      chk({31'h0, wake_out}, 32'h1);
      rdm(OFF_IRQ_STAT, 32'h2, 32'h2);
      rdm(OFF_CTRL0, 32'h2, 32'h0);
      hold <= 1'b0;
      $display("test wake done");
      conclude();
   end
endmodule : can_control_zero_tb_top
